/* shared/dasm_pkg.sv */
// Package of constants and types for the drive alarm and status monitor.
// Assumes a 40 MHz module clock and 16-bit parameter values.
`default_nettype none
package dasm_pkg;
	localparam int unsigned CLK_HZ          = 40000000;
	localparam int unsigned MS_PER_S        = 1000;
	localparam int unsigned CYC_PER_MS      = CLK_HZ / 1000;
	// Parameter indices on the non-cyclic access port.
	localparam logic [7:0] PIX_ALARM_MASK   = 8'h00;
	localparam logic [7:0] PIX_TEMP_LIMIT   = 8'h01;
	localparam logic [7:0] PIX_OT_TIMER     = 8'h02;
	localparam logic [7:0] PIX_UV_THRESH    = 8'h03;
	localparam logic [7:0] PIX_FS_TIMER     = 8'h04;
	localparam logic [7:0] PIX_PS_TIMER     = 8'h05;
	localparam logic [7:0] PIX_INPUT_STAT   = 8'h06;
	localparam logic [7:0] PIX_DCLINK_V     = 8'h07;
	localparam logic [7:0] PIX_MOTOR_TEMP   = 8'h08;
	localparam logic [7:0] PIX_SPEED_SET    = 8'h09;
	localparam logic [7:0] PIX_SPEED_ACT    = 8'h0a;
	localparam logic [7:0] PIX_CURR_PCT     = 8'h0b;
	localparam logic [7:0] PIX_CURR_LSB     = 8'h0c;
	localparam logic [7:0] PIX_ALARM_STAT   = 8'h0d;
	// Reset values and limits.
	localparam logic [15:0] MASK_RST        = 16'h0000;
	localparam logic [15:0] MASK_USED       = 16'h4101;
	localparam logic [15:0] TEMP_LIMIT_RST  = 16'd120;
	localparam logic [15:0] TEMP_LIMIT_MAX  = 16'd200;
	localparam logic [15:0] OT_TIMER_RST    = 16'd240;
	localparam logic [15:0] OT_TIMER_MAX    = 16'd600;
	localparam logic [15:0] UV_THRESH_RST   = 16'd200;
	localparam logic [15:0] UV_THRESH_MAX   = 16'd600;
	localparam logic [15:0] FS_TIMER_RST    = 16'd200;
	localparam logic [15:0] FS_TIMER_MIN    = 16'd20;
	localparam logic [15:0] FS_TIMER_MAX    = 16'd10000;
	localparam logic [15:0] PS_TIMER_RST    = 16'd20;
	localparam logic [15:0] DISP_MAX        = 16'h7fff;
	// Alarm positions.
	localparam int unsigned ALM_CFG         = 0;
	localparam int unsigned ALM_FIXSTOP     = 8;
	localparam int unsigned ALM_OVERTEMP    = 14;
	// Input status bit positions.
	localparam int unsigned IS_CU_EN        = 0;
	localparam int unsigned IS_MOD_INH      = 1;
	localparam int unsigned IS_CEN_INH      = 2;
	localparam int unsigned IS_PULSE_SUM    = 3;
	localparam int unsigned IS_HS_HOT_N     = 4;
	localparam int unsigned IS_SETUP_N      = 5;
	localparam int unsigned IS_SPZ_EN       = 6;
	localparam int unsigned IS_PREWARN_N    = 8;
	// Current filter: both cycle settings give tau/Ts = 320, gain 65536/320.
	localparam logic [15:0] PT1_GAIN        = 16'd205;
	localparam int unsigned CUR_FS_SHIFT    = 14;
	localparam logic [15:0] CUR_UA_PER_LSB  = 16'd2197;
	typedef enum logic [1:0] {
		DASM_OT_IDLE  = 2'b00,
		DASM_OT_COUNT = 2'b01,
		DASM_OT_TRIP  = 2'b10
	} dasm_ot_state_t;
endpackage
`default_nettype wire

/* design/dasm_top.sv */
// Alarm and status monitor for one servo axis: alarms, warnings, display values.
// Assumes measurement inputs on the module clock and binary inputs from pins.
//
// Operation
// - Mask bit zero enables alarm, resets zero.
// - Configuration error alarm can never be masked.
// - Bit 8 fixed stop, bit 14 overtemperature.
// - Software reset clears reset-class alarms.
// - Power-on alarms cleared only by hardware reset.
// - Warn when motor temperature reaches limit.
// - Overtemperature timer starts, default 240 s.
// - Timer expiry brakes then suppresses pulses.
// - New timer value waits for cooled motor.
// - Undervoltage warning below settable threshold.
// - Fixed stop timer expiry suppresses pulses.
// - Fixed stop timer below suppression refused.
// - Fixed stop monitoring independent of modes.
// - Input status bits zero to three.
// - Input status bits four, five, six, eight.
// - DC link voltage readable in volts.
// - Speed setpoint is position plus feedforward.
// - Displays captured at read request.
// - Current smoothed by first-order low-pass filter.
// - Smoothed current shown as percentage.
// - Motor temperature readable in degrees.
// - Read-only current weight per LSB.
`timescale 1ns/1ps
`default_nettype none
module dasm_top #(
	parameter int unsigned P_CYC_PER_MS = dasm_pkg::CYC_PER_MS,
	parameter int unsigned P_MS_PER_S   = dasm_pkg::MS_PER_S
) (
	// Clock, hardware reset and software reset request.
	input  wire logic        i_clk,
	input  wire logic        i_rstn,
	input  wire logic        i_sw_reset,
	// Binary input pins, asynchronous.
	input  wire logic        i_control_unit_enable,
	input  wire logic        i_module_pulse_inhibit,
	input  wire logic        i_central_pulse_inhibit,
	input  wire logic        i_pulse_enable_sum,
	input  wire logic        i_heatsink_overtemp_flag_n,
	input  wire logic        i_setup_mode_flag_n,
	input  wire logic        i_setpoint_zero_enable,
	input  wire logic        i_temperature_prewarning_n,
	// Measurements and internal events on the module clock.
	input  wire logic [15:0] i_motor_temp,
	input  wire logic [15:0] i_dclink_volt,
	input  wire logic [15:0] i_pos_ctrl_out,
	input  wire logic [15:0] i_speed_ff,
	input  wire logic [15:0] i_speed_act,
	input  wire logic [15:0] i_torque_current,
	input  wire logic        i_current_cycle_tick,
	input  wire logic        i_fixed_stop_fault,
	input  wire logic        i_config_error,
	input  wire logic        i_poweron_fault,
	// Non-cyclic parameter access.
	input  wire logic        i_par_req,
	input  wire logic        i_par_wr,
	input  wire logic [7:0]  i_par_index,
	input  wire logic [15:0] i_par_wdata,
	output logic             o_par_ack,
	output logic             o_par_err,
	output logic [15:0]      o_par_rdata,
	// Messages and drive actions.
	output logic             o_warn_temp,
	output logic             o_warn_undervolt,
	output logic             o_regen_brake,
	output logic             o_pulse_suppress,
	output logic [15:0]      o_alarm_active,
	output logic             o_poweron_alarm
);
	import dasm_pkg::*;

	function automatic logic [15:0] sat_pos(input logic signed [16:0] v);
		if (v < 17'sd0)
			sat_pos = 16'h0000;
		else if (v > $signed({1'b0, DISP_MAX}))
			sat_pos = DISP_MAX;
		else
			sat_pos = v[15:0];
	endfunction

	logic [7:0]  pin_s1_r;
	logic [7:0]  pin_s2_r;
	logic [15:0] mask_r;
	logic [15:0] temp_lim_r;
	logic [15:0] ot_tim_r;
	logic [15:0] uv_thr_r;
	logic [15:0] fs_tim_r;
	logic [15:0] ps_tim_r;
	logic [15:0] alarm_r;
	logic [15:0] ms_cnt_r;
	logic        ms_tick_r;
	logic [19:0] ot_cnt_r;
	logic [13:0] fs_cnt_r;
	logic [15:0] ps_cnt_r;
	logic        ps_done_r;
	logic signed [31:0] filt_r;
	dasm_ot_state_t ot_state_r;
	dasm_ot_state_t ot_state_nxt;

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			pin_s1_r <= 8'h00;
			pin_s2_r <= 8'h00;
		end else begin
			pin_s1_r <= {i_temperature_prewarning_n, i_setpoint_zero_enable,
				i_setup_mode_flag_n, i_heatsink_overtemp_flag_n, i_pulse_enable_sum,
				i_central_pulse_inhibit, i_module_pulse_inhibit, i_control_unit_enable};
			pin_s2_r <= pin_s1_r;
		end
	end

	wire [15:0] in_status = {7'h00, pin_s2_r[7], 1'b0, pin_s2_r[6:0]};

	// Parameter write decode and range checks.
	wire        wr_req    = i_par_req & i_par_wr;
	wire        wr_mask   = wr_req & (i_par_index == PIX_ALARM_MASK);
	wire        wr_tlim   = wr_req & (i_par_index == PIX_TEMP_LIMIT);
	wire        wr_ot     = wr_req & (i_par_index == PIX_OT_TIMER);
	wire        wr_uv     = wr_req & (i_par_index == PIX_UV_THRESH);
	wire        wr_fs     = wr_req & (i_par_index == PIX_FS_TIMER);
	wire        wr_ps     = wr_req & (i_par_index == PIX_PS_TIMER);
	wire        bad_tlim  = wr_tlim & (i_par_wdata > TEMP_LIMIT_MAX);
	wire        bad_ot    = wr_ot & (i_par_wdata > OT_TIMER_MAX);
	wire        bad_uv    = wr_uv & (i_par_wdata > UV_THRESH_MAX);
	wire        bad_fs    = wr_fs & ((i_par_wdata < FS_TIMER_MIN) |
		(i_par_wdata > FS_TIMER_MAX) | (i_par_wdata < ps_tim_r));
	wire        bad_ps    = wr_ps & (i_par_wdata > fs_tim_r);
	wire        wr_ro     = wr_req & ~(wr_mask | wr_tlim | wr_ot | wr_uv | wr_fs | wr_ps);
	wire        wr_bad    = bad_tlim | bad_ot | bad_uv | bad_fs | bad_ps | wr_ro;

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			mask_r     <= MASK_RST;
			temp_lim_r <= TEMP_LIMIT_RST;
			ot_tim_r   <= OT_TIMER_RST;
			uv_thr_r   <= UV_THRESH_RST;
			fs_tim_r   <= FS_TIMER_RST;
			ps_tim_r   <= PS_TIMER_RST;
		end else begin
			if (wr_mask)
				mask_r <= i_par_wdata & MASK_USED;
			if (wr_tlim & ~bad_tlim)
				temp_lim_r <= i_par_wdata;
			if (wr_ot & ~bad_ot)
				ot_tim_r <= i_par_wdata;
			if (wr_uv & ~bad_uv)
				uv_thr_r <= i_par_wdata;
			if (wr_fs & ~bad_fs)
				fs_tim_r <= i_par_wdata;
			if (wr_ps & ~bad_ps)
				ps_tim_r <= i_par_wdata;
		end
	end

	// Millisecond time base for the overtemperature, fixed stop and pulse suppression timers.
	wire ms_wrap = (ms_cnt_r == 16'(P_CYC_PER_MS - 1));

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			ms_cnt_r  <= 16'h0000;
			ms_tick_r <= 1'b0;
		end else begin
			ms_cnt_r  <= ms_wrap ? 16'h0000 : ms_cnt_r + 16'h0001;
			ms_tick_r <= ms_wrap;
		end
	end

	// Motor overtemperature warning and shutdown timer.
	wire temp_hot  = (i_motor_temp >= temp_lim_r);
	wire ot_expire = (ot_cnt_r == 20'h00000);

	always_comb begin
		ot_state_nxt = ot_state_r;
		case (ot_state_r)
			DASM_OT_IDLE: begin
				if (temp_hot)
					ot_state_nxt = DASM_OT_COUNT;
			end
			DASM_OT_COUNT: begin
				if (!temp_hot)
					ot_state_nxt = DASM_OT_IDLE;
				else if (ot_expire)
					ot_state_nxt = DASM_OT_TRIP;
			end
			DASM_OT_TRIP: begin
				if (!temp_hot)
					ot_state_nxt = DASM_OT_IDLE;
			end
			default: ot_state_nxt = DASM_OT_IDLE;
		endcase
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			ot_state_r <= DASM_OT_IDLE;
			ot_cnt_r   <= 20'h00000;
		end else begin
			ot_state_r <= ot_state_nxt;
			if (ot_state_r == DASM_OT_IDLE)
				ot_cnt_r <= 20'(ot_tim_r * P_MS_PER_S);
			else if (ms_tick_r && !ot_expire)
				ot_cnt_r <= ot_cnt_r - 20'h00001;
		end
	end

	// Fixed stop watchdog on the speed controller output, whatever the mode.
	wire fs_expire = ({2'b00, fs_cnt_r} >= fs_tim_r);

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn)
			fs_cnt_r <= 14'h0000;
		else if (!i_fixed_stop_fault)
			fs_cnt_r <= 14'h0000;
		else if (ms_tick_r && !fs_expire)
			fs_cnt_r <= fs_cnt_r + 14'h0001;
	end

	// Reset-class alarms; the set term wins over a software reset.
	wire [15:0] alarm_set;
	assign alarm_set[ALM_CFG]         = i_config_error;
	assign alarm_set[ALM_FIXSTOP]     = fs_expire & i_fixed_stop_fault & ~mask_r[ALM_FIXSTOP];
	assign alarm_set[ALM_OVERTEMP]    = (ot_state_r == DASM_OT_TRIP) &
		~mask_r[ALM_OVERTEMP];
	assign alarm_set[7:1]             = 7'h00;
	assign alarm_set[13:9]            = 5'h00;
	assign alarm_set[15]              = 1'b0;

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn)
			alarm_r <= 16'h0000;
		else
			alarm_r <= alarm_set | (i_sw_reset ? 16'h0000 : alarm_r);
	end

	// After an overtemperature shutdown the axis brakes before pulses go off.
	wire brake_on = alarm_r[ALM_OVERTEMP];

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			ps_cnt_r  <= 16'h0000;
			ps_done_r <= 1'b0;
		end else if (!brake_on) begin
			ps_cnt_r  <= 16'h0000;
			ps_done_r <= 1'b0;
		end else begin
			if (ms_tick_r && !ps_done_r)
				ps_cnt_r <= ps_cnt_r + 16'h0001;
			ps_done_r <= (ps_cnt_r >= ps_tim_r);
		end
	end

	// Smoothed torque current, updated once per current controller cycle.
	wire signed [31:0] filt_err  = $signed({{16{i_torque_current[15]}}, i_torque_current}) -
		(filt_r >>> 16);
	wire signed [47:0] filt_step = filt_err * $signed({1'b0, PT1_GAIN});

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn)
			filt_r <= 32'sh00000000;
		else if (i_current_cycle_tick)
			filt_r <= filt_r + filt_step[31:0];
	end

	wire signed [15:0] filt_out  = filt_r[31:16];
	wire [15:0]        filt_abs  = filt_out[15] ? 16'(-filt_out) : filt_out;
	wire [22:0]        pct_prod  = filt_abs * 7'd100;
	wire [15:0]        curr_pct  = sat_pos($signed({8'h00, pct_prod[22:CUR_FS_SHIFT]}));
	wire signed [16:0] spd_sum   = $signed({i_pos_ctrl_out[15], i_pos_ctrl_out}) +
		$signed({i_speed_ff[15], i_speed_ff});
	wire [15:0]        spd_set   = sat_pos(spd_sum);
	wire [15:0]        spd_act   = sat_pos($signed({i_speed_act[15], i_speed_act}));

	// Read mux; displays are taken at the request cycle, not sampled periodically.
	logic [15:0] rd_val;
	always_comb begin
		case (i_par_index)
			PIX_ALARM_MASK: rd_val = mask_r;
			PIX_TEMP_LIMIT: rd_val = temp_lim_r;
			PIX_OT_TIMER:   rd_val = ot_tim_r;
			PIX_UV_THRESH:  rd_val = uv_thr_r;
			PIX_FS_TIMER:   rd_val = fs_tim_r;
			PIX_PS_TIMER:   rd_val = ps_tim_r;
			PIX_INPUT_STAT: rd_val = in_status;
			PIX_DCLINK_V:   rd_val = sat_pos($signed({1'b0, i_dclink_volt}));
			PIX_MOTOR_TEMP: rd_val = sat_pos($signed({1'b0, i_motor_temp}));
			PIX_SPEED_SET:  rd_val = spd_set;
			PIX_SPEED_ACT:  rd_val = spd_act;
			PIX_CURR_PCT:   rd_val = curr_pct;
			PIX_CURR_LSB:   rd_val = CUR_UA_PER_LSB;
			PIX_ALARM_STAT: rd_val = alarm_r;
			default:        rd_val = 16'h0000;
		endcase
	end

	wire rd_bad = i_par_req & ~i_par_wr & (i_par_index > PIX_ALARM_STAT);

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_par_ack   <= 1'b0;
			o_par_err   <= 1'b0;
			o_par_rdata <= 16'h0000;
		end else begin
			o_par_ack <= i_par_req;
			o_par_err <= i_par_req & (wr_bad | rd_bad);
			if (i_par_req && !i_par_wr)
				o_par_rdata <= rd_val;
		end
	end

	// Messages and drive actions.
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_warn_temp      <= 1'b0;
			o_warn_undervolt <= 1'b0;
			o_regen_brake    <= 1'b0;
			o_pulse_suppress <= 1'b0;
			o_alarm_active   <= 16'h0000;
			o_poweron_alarm  <= 1'b0;
		end else begin
			o_warn_temp      <= temp_hot;
			o_warn_undervolt <= (i_dclink_volt < uv_thr_r);
			o_regen_brake    <= brake_on & ~ps_done_r;
			o_pulse_suppress <= alarm_r[ALM_FIXSTOP] | (brake_on & ps_done_r) |
				alarm_r[ALM_CFG];
			o_alarm_active   <= alarm_r;
			o_poweron_alarm  <= o_poweron_alarm | i_poweron_fault;
		end
	end

endmodule // dasm_top
`default_nettype wire

/* testbench/dasm_checker.sv */
// Port checks for the alarm and status monitor, bound into dasm_top.
// Assumes one module clock and the active-low hardware reset.
`timescale 1ns/1ps
`default_nettype none
module dasm_checker
	import dasm_pkg::*;
(
	// Causes.
	input wire logic        i_clk,
	input wire logic        i_rstn,
	input wire logic        i_sw_reset,
	input wire logic        i_fixed_stop_fault,
	input wire logic        i_config_error,
	input wire logic        i_poweron_fault,
	input wire logic        i_par_req,
	// Effects.
	input wire logic        o_par_ack,
	input wire logic        o_par_err,
	input wire logic        o_regen_brake,
	input wire logic        o_pulse_suppress,
	input wire logic [15:0] o_alarm_active,
	input wire logic        o_poweron_alarm
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rstn);
	property p_ack; o_par_ack == $past(i_par_req); endproperty
	a_ack: assert property (p_ack) else $error("answer missing");
	property p_err; o_par_err |-> o_par_ack; endproperty
	a_err: assert property (p_err) else $error("error without answer");
	property p_free; (o_alarm_active & ~MASK_USED) == 16'h0000; endproperty
	a_free: assert property (p_free) else $error("unassigned alarm set");
	property p_cfg; i_config_error |-> ##[1:3] o_alarm_active[ALM_CFG]; endproperty
	a_cfg: assert property (p_cfg) else $error("config alarm missing");
	property p_pon; o_poweron_alarm || i_poweron_fault |=> o_poweron_alarm; endproperty
	a_pon: assert property (p_pon) else $error("power-on alarm lost");
	property p_clr;
		i_sw_reset && !i_fixed_stop_fault |-> ##[1:2] !o_alarm_active[ALM_FIXSTOP];
	endproperty
	a_clr: assert property (p_clr) else $error("alarm kept after clear");
	property p_fs; o_alarm_active[ALM_FIXSTOP] |-> ##[0:2] o_pulse_suppress; endproperty
	a_fs: assert property (p_fs) else $error("pulses not suppressed");
	property p_brk;
		$rose(o_alarm_active[ALM_OVERTEMP]) && !o_pulse_suppress |-> ##[0:2] o_regen_brake;
	endproperty
	a_brk: assert property (p_brk) else $error("no braking");
	c_ot: cover property ($rose(o_alarm_active[ALM_OVERTEMP]));
	c_fs: cover property ($rose(o_alarm_active[ALM_FIXSTOP]));
	c_err: cover property (o_par_err);
endmodule // dasm_checker
bind dasm_top dasm_checker u_dasm_checker (.i_clk, .i_rstn, .i_sw_reset, .i_fixed_stop_fault,
	.i_config_error, .i_poweron_fault, .i_par_req, .o_par_ack, .o_par_err, .o_regen_brake,
	.o_pulse_suppress,
	.o_alarm_active, .o_poweron_alarm);
`default_nettype wire

/* testbench/dasm_servo_model.sv */
// Servo-side requester of non-cyclic parameter reads and writes.
// Assumes the monitor answers on the cycle after a one-cycle request.
`timescale 1ns/1ps
`default_nettype none
module dasm_servo_model (
	// Clock and answer.
	input  wire logic        i_clk,
	input  wire logic        i_par_ack,
	input  wire logic        i_par_err,
	input  wire logic [15:0] i_par_rdata,
	// Request.
	output var  logic        o_par_req,
	output var  logic        o_par_wr,
	output var  logic [7:0]  o_par_index,
	output var  logic [15:0] o_par_wdata
);
	initial begin
		o_par_req = 1'b0;
		o_par_wr = 1'b0;
		o_par_index = 8'hff;
		o_par_wdata = 16'h0000;
	end
	task automatic access(input logic wr, input logic [7:0] ix, input logic [15:0] wd,
		output logic ak, output logic er, output logic [15:0] rd);
		@(negedge i_clk);
		o_par_req = 1'b1;
		o_par_wr = wr;
		o_par_index = ix;
		o_par_wdata = wd;
		@(negedge i_clk);
		o_par_req = 1'b0;
		ak = i_par_ack;
		er = i_par_err;
		rd = i_par_rdata;
		// Released lines must not keep the old value.
		o_par_index = ~ix;
		o_par_wdata = ~wd;
	endtask
endmodule // dasm_servo_model
`default_nettype wire

/* testbench/test_drive_alarm_and_status_monitor.sv */
// Self-checking bench for the alarm and status monitor.
// Assumes dasm_servo_model as requester and shortened ms and s counts.
`timescale 1ns/1ps
`default_nettype none
module test_drive_alarm_and_status_monitor;
	import dasm_pkg::*;
	typedef struct packed {
		logic wr;
		logic [7:0] idx;
		logic [15:0] wd;
		logic er;
		logic [15:0] rd;
	} dasm_row_t;
	logic i_clk = 1'b0, i_rstn = 1'b0, i_sw_reset = 1'b0;
	logic [7:0] pins = 8'hd5;
	logic [15:0] i_motor_temp = 16'd25, i_dclink_volt = 16'd540, i_pos_ctrl_out = 16'd100;
	logic [15:0] i_speed_ff = 16'd23, i_speed_act = 16'd1500, i_torque_current = 16'h0;
	logic i_current_cycle_tick = 1'b0, i_fixed_stop_fault = 1'b0;
	logic i_config_error = 1'b0, i_poweron_fault = 1'b0;
	wire logic i_par_req, i_par_wr, o_par_ack, o_par_err, o_warn_temp, o_warn_undervolt;
	wire logic o_regen_brake, o_pulse_suppress, o_poweron_alarm;
	wire logic [7:0] i_par_index;
	wire logic [15:0] i_par_wdata, o_par_rdata, o_alarm_active;
	wire logic [16:0] watch = {o_pulse_suppress, o_alarm_active};
	int n_fail = 0, checked = 0, cyc = 0, t0, k;
	logic ak, er;
	logic [15:0] rd;
	dasm_row_t rows [$] = '{
		'{'0, PIX_ALARM_MASK, '0, '0, MASK_RST},
		'{'0, PIX_TEMP_LIMIT, '0, '0, TEMP_LIMIT_RST},
		'{'0, PIX_OT_TIMER, '0, '0, OT_TIMER_RST},
		'{'0, PIX_UV_THRESH, '0, '0, UV_THRESH_RST},
		'{'0, PIX_FS_TIMER, '0, '0, FS_TIMER_RST},
		'{'0, PIX_PS_TIMER, '0, '0, PS_TIMER_RST},
		'{'0, PIX_INPUT_STAT, '0, '0, 16'h0155},
		'{'0, PIX_DCLINK_V, '0, '0, 16'd540},
		'{'0, PIX_MOTOR_TEMP, '0, '0, 16'd25},
		'{'0, PIX_SPEED_SET, '0, '0, 16'd123},
		'{'0, PIX_SPEED_ACT, '0, '0, 16'd1500},
		'{'0, PIX_CURR_LSB, '0, '0, CUR_UA_PER_LSB},
		'{'0, 8'h0e, '0, '1, '0},
		'{'1, PIX_TEMP_LIMIT, 16'd201, '1, '0},
		'{'0, PIX_TEMP_LIMIT, '0, '0, TEMP_LIMIT_RST},
		'{'1, PIX_OT_TIMER, 16'd601, '1, '0},
		'{'1, PIX_UV_THRESH, 16'd601, '1, '0},
		'{'1, PIX_FS_TIMER, 16'd19, '1, '0},
		'{'1, PIX_INPUT_STAT, 16'h0001, '1, '0},
		'{'1, PIX_PS_TIMER, 16'd100, '0, '0},
		'{'1, PIX_FS_TIMER, 16'd50, '1, '0},
		'{'1, PIX_PS_TIMER, 16'd20, '0, '0},
		'{'1, PIX_FS_TIMER, 16'd20, '0, '0},
		'{'1, PIX_ALARM_MASK, 16'hffff, '0, '0},
		'{'0, PIX_ALARM_MASK, '0, '0, MASK_USED},
		'{'1, PIX_ALARM_MASK, 16'h0000, '0, '0},
		'{'1, PIX_UV_THRESH, 16'd600, '0, '0},
		'{'1, PIX_OT_TIMER, 16'd3, '0, '0}
	};
	dasm_servo_model u_dasm_servo_model (.i_clk, .i_par_ack(o_par_ack), .i_par_err(o_par_err),
		.i_par_rdata(o_par_rdata), .o_par_req(i_par_req), .o_par_wr(i_par_wr),
		.o_par_index(i_par_index), .o_par_wdata(i_par_wdata));
	dasm_top #(.P_CYC_PER_MS(4), .P_MS_PER_S(2)) u_dasm_top (.i_clk, .i_rstn, .i_sw_reset,
		.i_control_unit_enable(pins[0]), .i_module_pulse_inhibit(pins[1]),
		.i_central_pulse_inhibit(pins[2]), .i_pulse_enable_sum(pins[3]),
		.i_heatsink_overtemp_flag_n(pins[4]), .i_setup_mode_flag_n(pins[5]),
		.i_setpoint_zero_enable(pins[6]), .i_temperature_prewarning_n(pins[7]),
		.i_motor_temp, .i_dclink_volt, .i_pos_ctrl_out, .i_speed_ff, .i_speed_act,
		.i_torque_current, .i_current_cycle_tick, .i_fixed_stop_fault, .i_config_error,
		.i_poweron_fault, .i_par_req, .i_par_wr, .i_par_index, .i_par_wdata, .o_par_ack,
		.o_par_err, .o_par_rdata, .o_warn_temp, .o_warn_undervolt, .o_regen_brake,
		.o_pulse_suppress, .o_alarm_active, .o_poweron_alarm);
	always #12.5 i_clk = ~i_clk;
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		if (cyc == 12000) begin
			n_fail++;
			print_verdict();
		end
	end
	task automatic chk(string nm, logic [15:0] ex, logic [15:0] got);
		checked++;
		if (got !== ex) begin
			n_fail++;
			$display("FAIL %s expected %h seen %h", nm, ex, got);
		end
	endtask
	task automatic rng(string nm, logic [15:0] lo, logic [15:0] hi, logic [15:0] got);
		checked++;
		if (^got === 1'bx || got < lo || got > hi) begin
			n_fail++;
			$display("FAIL %s expected %0d to %0d seen %0d", nm, lo, hi, got);
		end
	endtask
	task automatic step(int n);
		repeat (n) @(negedge i_clk);
	endtask
	task automatic acc(dasm_row_t r);
		u_dasm_servo_model.access(r.wr, r.idx, r.wd, ak, er, rd);
		chk("ack", 16'h1, {15'h0, ak});
		chk("err", {15'h0, r.er}, {15'h0, er});
		if (!r.wr) chk("rdata", r.rd, rd);
	endtask
	task automatic wr(logic [7:0] ix, logic [15:0] v);
		acc('{1'b1, ix, v, 1'b0, 16'h0});
	endtask
	task automatic rdv(logic [7:0] ix);
		u_dasm_servo_model.access(1'b0, ix, 16'h0, ak, er, rd);
	endtask
	task automatic waitb(int b);
		k = 0;
		while (watch[b] !== 1'b1 && k < 300) begin
			step(1);
			k++;
		end
	endtask
	task automatic swp();
		i_sw_reset = 1'b1;
		step(1);
		i_sw_reset = 1'b0;
		step(2);
	endtask
	initial begin
		step(6);
		i_rstn = 1'b1;
		step(2);
		chk("alarms", 16'h0, o_alarm_active);
		chk("actions", 16'h0, {11'h0, o_warn_temp, o_warn_undervolt, o_regen_brake,
			o_pulse_suppress, o_poweron_alarm});
		$display("done reset");
		foreach (rows[i]) acc(rows[i]);
		pins = 8'haa;
		step(3);
		rdv(PIX_INPUT_STAT);
		chk("status", 16'h012a, rd);
		chk("uv_on", 16'h1, {15'h0, o_warn_undervolt});
		i_dclink_volt = 16'd700;
		step(3);
		chk("uv_off", 16'h0, {15'h0, o_warn_undervolt});
		$display("done table");
		i_torque_current = 16'd16384;
		i_current_cycle_tick = 1'b1;
		step(320);
		rdv(PIX_CURR_PCT);
		rng("cur_tau", 16'd60, 16'd66, rd);
		step(2700);
		rdv(PIX_CURR_PCT);
		rng("cur_full", 16'd98, 16'd100, rd);
		i_current_cycle_tick = 1'b0;
		$display("done current");
		i_motor_temp = 16'd130;
		t0 = cyc;
		step(3);
		chk("warn_on", 16'h1, {15'h0, o_warn_temp});
		wr(PIX_OT_TIMER, 16'd10);
		waitb(ALM_OVERTEMP);
		rng("ot_first", 16'd22, 16'd32, 16'(cyc - t0));
		step(2);
		chk("brake", 16'h1, {15'h0, o_regen_brake});
		t0 = cyc;
		waitb(16);
		rng("suppress", 16'd76, 16'd86, 16'(cyc - t0));
		i_motor_temp = 16'd25;
		step(3);
		chk("warn_off", 16'h0, {15'h0, o_warn_temp});
		swp();
		chk("ot_clear", 16'h0, o_alarm_active);
		i_poweron_fault = 1'b1;
		step(1);
		i_poweron_fault = 1'b0;
		swp();
		chk("poweron", 16'h1, {15'h0, o_poweron_alarm});
		i_motor_temp = 16'd130;
		t0 = cyc;
		waitb(ALM_OVERTEMP);
		rng("ot_second", 16'd78, 16'd88, 16'(cyc - t0));
		i_motor_temp = 16'd25;
		step(3);
		swp();
		wr(PIX_ALARM_MASK, 16'h4000);
		i_motor_temp = 16'd130;
		waitb(ALM_OVERTEMP);
		chk("masked", 16'h0, o_alarm_active);
		i_motor_temp = 16'd25;
		wr(PIX_ALARM_MASK, 16'h0000);
		$display("done overtemp");
		i_fixed_stop_fault = 1'b1;
		t0 = cyc;
		waitb(ALM_FIXSTOP);
		rng("fixstop", 16'd76, 16'd88, 16'(cyc - t0));
		i_fixed_stop_fault = 1'b0;
		swp();
		chk("fs_clear", 16'h0, o_alarm_active);
		wr(PIX_ALARM_MASK, 16'hffff);
		i_config_error = 1'b1;
		i_fixed_stop_fault = 1'b1;
		step(100);
		chk("config", 16'h0001, o_alarm_active);
		rdv(PIX_ALARM_STAT);
		chk("alarm_stat", 16'h0001, rd);
		i_config_error = 1'b0;
		i_fixed_stop_fault = 1'b0;
		i_rstn = 1'b0;
		step(2);
		i_rstn = 1'b1;
		step(2);
		chk("poweron_hw", 16'h0, {15'h0, o_poweron_alarm});
		rdv(PIX_ALARM_MASK);
		chk("mask_reset", MASK_RST, rd);
		$display("done alarms");
		print_verdict();
	end
endmodule // test_drive_alarm_and_status_monitor
`default_nettype wire
